/* File: design/isp_device.sv */
// Chosen here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
module isp_device
    import isp_pkg::*;
#(
    parameter int ADDR_W    = 12,
    parameter int ERASE_LEN = ERASE_CYC,
    parameter int WRITE_LEN = WRITE_CYC,
    parameter logic [7:0] SIG_BASE = 8'h5a  // Arbitrary value.
) (
    // Clock and reset.
    input  wire logic i_sys_clk,
    input  wire logic i_rstn,
    // Serial link.
    isp_link_if.device link,
    // Status.
    output logic       o_prog_enabled,
    output logic       o_busy,
    output logic [2:0] o_lock_bits
);
    if (ADDR_W < 9 || ADDR_W > 16 || ERASE_LEN < 1 || WRITE_LEN < 1
        || ERASE_LEN >= 2**26 || WRITE_LEN >= 2**26) begin : g_bad_params
        $error("isp_device: unsupported parameters");
    end

    localparam int UW = ADDR_W - 8;

    // Three-stage synchronisers for reset pin, clock and data pins.
    logic [2:0] s1_q, s2_q, s3_q;
    logic [2:0] pins;
    assign pins = {link.rst_pin, link.sck, link.mosi};
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge i_sys_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    s1_q[g] <= 1'b0;
                    s2_q[g] <= 1'b0;
                    s3_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= pins[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                end
            end
        end
    endgenerate

    typedef enum logic [1:0] {
        BUSY_NONE  = 2'b00,
        BUSY_WRITE = 2'b01,
        BUSY_ERASE = 2'b10
    } busy_type;

    logic [7:0] mem [2**ADDR_W];
    logic [2:0] lvl_q, lvl_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d, tx_q, tx_d;
    logic [1:0] idx_q, idx_d;
    logic [7:0] b1_q, b1_d, b2_q, b2_d, b3_q, b3_d;
    logic       en_q, en_d;
    logic       pg_q, pg_d, pgwr_q, pgwr_d;
    logic [7:0] pcnt_q, pcnt_d;
    logic [2:0] lock_q, lock_d;
    busy_type   busy_q, busy_d;
    logic [25:0] tmr_q, tmr_d;
    logic [ADDR_W-1:0] last_q, last_d;
    logic       rise, fall, done;
    logic [7:0] rx;
    logic       we, erase_all;
    logic [ADDR_W-1:0] wa, ra;
    logic [7:0] wd;
    logic       miso_q, miso_d, bsy_q, bsy_d;

    // A read while busy: erase gives a fixed value, a write in flight
    // answers with its inverted MSB so the programmer can poll.
    function automatic logic [7:0] rd_byte(input logic [ADDR_W-1:0] a);
        logic [7:0] v;
        v = mem[a];
        if (busy_q == BUSY_ERASE) begin
            v = ERASE_READ;
        end else if (busy_q == BUSY_WRITE && a == last_q) begin
            v = {~mem[a][7], mem[a][6:0]};
        end
        return v;
    endfunction

    always_comb begin
        lvl_d = lvl_q;
        for (int i = 0; i < 3; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                lvl_d[i] = s3_q[i];
            end
        end
        rise = lvl_d[1] && !lvl_q[1];
        fall = !lvl_d[1] && lvl_q[1];
        rx = {sh_q[6:0], lvl_q[0]};
        done = rise && bit_q == 3'h7;
        bit_d = rise ? bit_q + 3'h1 : bit_q;
        sh_d = rise ? rx : sh_q;
        tx_d = tx_q;
        if (fall && bit_q != 3'h0) begin
            tx_d = {tx_q[6:0], 1'b0};
        end
        idx_d = idx_q;
        b1_d = b1_q;
        b2_d = b2_q;
        b3_d = b3_q;
        en_d = en_q;
        pg_d = pg_q;
        pgwr_d = pgwr_q;
        pcnt_d = pcnt_q;
        lock_d = lock_q;
        busy_d = busy_q;
        tmr_d = tmr_q;
        last_d = last_q;
        we = 1'b0;
        wa = last_q;
        wd = rx;
        erase_all = 1'b0;
        ra = {b2_q[UW-1:0], b3_q};
        if (busy_q != BUSY_NONE) begin
            if (tmr_q == 26'h0) begin
                busy_d = BUSY_NONE;
                erase_all = busy_q == BUSY_ERASE;
            end else begin
                tmr_d = tmr_q - 26'h1;
            end
        end
        if (done && pg_q) begin
            // Every byte after the page address is data.
            ra = {b2_q[UW-1:0], pcnt_q + 8'h1};
            if (pgwr_q) begin
                we = busy_q == BUSY_NONE;
                wa = {b2_q[UW-1:0], pcnt_q};
                last_d = wa;
            end else begin
                tx_d = rd_byte(ra);
            end
            pcnt_d = pcnt_q + 8'h1;
            if (pcnt_q == 8'(PAGE_BYTES - 1)) begin
                pg_d = 1'b0;
                idx_d = 2'h0;
                if (pgwr_q && busy_q == BUSY_NONE) begin
                    busy_d = BUSY_WRITE;
                    tmr_d = 26'(WRITE_LEN - 1);
                end
            end
        end else if (done) begin
            idx_d = idx_q + 2'h1;
            case (idx_q)
                2'h0: begin
                    b1_d = rx;
                end
                2'h1: begin
                    b2_d = rx;
                    if (en_q && (b1_q == OP_PAGE_RD
                                 || b1_q == OP_PAGE_WR)) begin
                        pg_d = 1'b1;
                        pgwr_d = b1_q == OP_PAGE_WR;
                        pcnt_d = 8'h0;
                        tx_d = rd_byte({rx[UW-1:0], 8'h0});
                    end
                end
                2'h2: begin
                    b3_d = rx;
                    ra = {b2_q[UW-1:0], rx};
                    if (b1_q == OP_PREFIX && b2_q == OP_ENABLE2) begin
                        tx_d = ENABLE_ECHO;
                    end else if (!en_q) begin
                        tx_d = 8'h0;
                    end else if (b1_q == OP_READ) begin
                        tx_d = rd_byte(ra);
                    end else if (b1_q == OP_LOCK_RD) begin
                        tx_d = 8'h0;
                        tx_d[LOCK_RD_LSB+:3] = lock_q;
                    end else if (b1_q == OP_SIG) begin
                        tx_d = SIG_BASE ^ rx;
                    end
                end
                default: begin
                    ra = {b2_q[UW-1:0], b3_q};
                    if (b1_q == OP_PREFIX && b2_q == OP_ENABLE2) begin
                        en_d = 1'b1;
                    end else if (en_q && busy_q == BUSY_NONE) begin
                        if (b1_q == OP_PREFIX
                            && b2_q[7:5] == ERASE_TAG) begin
                            busy_d = BUSY_ERASE;
                            tmr_d = 26'(ERASE_LEN - 1);
                        end else if (b1_q == OP_WRITE) begin
                            we = 1'b1;
                            wa = ra;
                            last_d = ra;
                            busy_d = BUSY_WRITE;
                            tmr_d = 26'(WRITE_LEN - 1);
                        end else if (b1_q == OP_PREFIX
                                     && b2_q[7:2] == LOCK_TAG) begin
                            case ({b2_q[SEL_LOW_BIT],
                                   b2_q[SEL_HIGH_BIT]})
                                2'b01:   lock_d[0] = 1'b1;
                                2'b10:   lock_d[1] = 1'b1;
                                2'b11:   lock_d[2] = 1'b1;
                                default: lock_d = lock_q;
                            endcase
                        end
                    end
                end
            endcase
        end
        // Within a session the output bit moves only after a falling edge,
        // so it never changes while the programmer may be sampling it.
        miso_d = miso_q;
        if (fall) begin
            miso_d = tx_d[7];
        end
        bsy_d = busy_d != BUSY_NONE;
        // Dropping the reset pin ends the session at once.
        if (!lvl_q[2]) begin
            miso_d = 1'b0;
            en_d = 1'b0;
            idx_d = 2'h0;
            bit_d = 3'h0;
            pg_d = 1'b0;
            tx_d = 8'h0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            lvl_q  <= 3'h0;
            bit_q  <= 3'h0;
            sh_q   <= 8'h0;
            tx_q   <= 8'h0;
            idx_q  <= 2'h0;
            b1_q   <= 8'h0;
            b2_q   <= 8'h0;
            b3_q   <= 8'h0;
            en_q   <= 1'b0;
            pg_q   <= 1'b0;
            pgwr_q <= 1'b0;
            pcnt_q <= 8'h0;
            lock_q <= 3'h0;
            busy_q <= BUSY_NONE;
            tmr_q  <= 26'h0;
            last_q <= '0;
            miso_q <= 1'b0;
            bsy_q  <= 1'b0;
        end else begin
            lvl_q  <= lvl_d;
            bit_q  <= bit_d;
            sh_q   <= sh_d;
            tx_q   <= tx_d;
            idx_q  <= idx_d;
            b1_q   <= b1_d;
            b2_q   <= b2_d;
            b3_q   <= b3_d;
            en_q   <= en_d;
            pg_q   <= pg_d;
            pgwr_q <= pgwr_d;
            pcnt_q <= pcnt_d;
            lock_q <= lock_d;
            busy_q <= busy_d;
            tmr_q  <= tmr_d;
            last_q <= last_d;
            miso_q <= miso_d;
            bsy_q  <= bsy_d;
        end
    end

    // The array is non-volatile, so it takes no reset.
    always_ff @(posedge i_sys_clk) begin
        if (erase_all) begin
            for (int i = 0; i < 2**ADDR_W; i++) begin
                mem[i] <= ERASED_BYTE;
            end
        end else if (we) begin
            mem[wa] <= wd;
        end
    end

    assign link.miso      = miso_q;
    assign o_prog_enabled = en_q;
    assign o_busy         = bsy_q;
    assign o_lock_bits    = lock_q;
endmodule

/* File: design/isp_programmer.sv */
`timescale 1ns/100ps
module isp_programmer
    import isp_pkg::*;
#(
    parameter int HALF = SCK_HALF_CYC
) (
    // Clock and reset.
    input  wire logic        i_sys_clk,
    input  wire logic        i_rstn,
    // AHB-Lite slave.
    input  wire logic        i_hsel,
    input  wire logic [7:0]  i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic [31:0]      o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // Serial link.
    isp_link_if.programmer   link
);
    if (2 * HALF < SCK_MIN_DIV || HALF > 255) begin : g_bad_half
        $error("isp_programmer: serial clock too fast");
    end

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW  = 2'b01,
        ST_HIGH = 2'b10
    } st_type;

    st_type      st_q, st_d;
    logic [7:0]  div_q, div_d, grd_q, grd_d;
    logic [2:0]  bit_q, bit_d;
    logic [7:0]  tx_q, tx_d, rx_q, rx_d, rxr_q, rxr_d;
    logic        sck_q, sck_d, mosi_q, mosi_d, rst_q, rst_d;
    logic        wph_q, wph_d;
    logic [7:0]  wa_q, wa_d;
    logic [31:0] rd_q, rd_d;
    logic        m1_q, m2_q, m3_q, miso_q, miso_d;
    logic        tick, acc;
    logic        rdy_q;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            m1_q <= 1'b0;
            m2_q <= 1'b0;
            m3_q <= 1'b0;
        end else begin
            m1_q <= link.miso;
            m2_q <= m1_q;
            m3_q <= m2_q;
        end
    end

    always_comb begin
        miso_d = (m2_q == m3_q) ? m3_q : miso_q;
        acc = i_hsel && i_hready && i_htrans[1];
        wph_d = acc && i_hwrite;
        wa_d = acc ? i_haddr : wa_q;
        rd_d = 32'h0;
        if (acc && !i_hwrite) begin
            case (i_haddr)
                REG_CTRL:   rd_d[CTRL_RST_BIT] = rst_q;
                REG_STATUS: begin
                    rd_d[STAT_BUSY_BIT] = st_q != ST_IDLE;
                    rd_d[STAT_GRD_BIT] = grd_q != 8'h0;
                end
                REG_RXDATA: rd_d[7:0] = rxr_q;
                default:    rd_d = 32'h0;
            endcase
        end
        rst_d = rst_q;
        st_d = st_q;
        div_d = div_q;
        bit_d = bit_q;
        tx_d = tx_q;
        rx_d = rx_q;
        rxr_d = rxr_q;
        sck_d = sck_q;
        mosi_d = mosi_q;
        grd_d = (grd_q != 8'h0) ? grd_q - 8'h1 : grd_q;
        tick = div_q == 8'(HALF - 1);
        if (st_q != ST_IDLE) begin
            div_d = tick ? 8'h0 : div_q + 8'h1;
        end
        case (st_q)
            ST_LOW: if (tick) begin
                sck_d = 1'b1;
                st_d = ST_HIGH;
            end
            ST_HIGH: begin
                // Both ends synchronise, so the answer to a falling edge
                // arrives about eight cycles late; sampling mid-high
                // leaves room on either side.
                if (div_q == 8'(HALF / 2 - 1)) begin
                    rx_d = {rx_q[6:0], miso_q};
                end
                if (tick) begin
                    sck_d = 1'b0;
                    bit_d = bit_q + 3'h1;
                    if (bit_q == 3'h7) begin
                        st_d = ST_IDLE;
                        rxr_d = rx_q;
                    end else begin
                        mosi_d = tx_q[6];
                        tx_d = {tx_q[6:0], 1'b0};
                        st_d = ST_LOW;
                    end
                end
            end
            default: st_d = ST_IDLE;
        endcase
        if (wph_q && wa_q == REG_CTRL) begin
            rst_d = i_hwdata[CTRL_RST_BIT];
            if (i_hwdata[CTRL_RST_BIT] && !rst_q) begin
                grd_d = 8'(GUARD_CYC);
            end
        end
        // A byte is refused while one is in flight or the guard runs.
        if (wph_q && wa_q == REG_TXDATA && st_q == ST_IDLE
            && grd_q == 8'h0 && rst_q) begin
            tx_d = i_hwdata[7:0];
            mosi_d = i_hwdata[7];
            div_d = 8'h0;
            bit_d = 3'h0;
            st_d = ST_LOW;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q   <= ST_IDLE;
            div_q  <= 8'h0;
            grd_q  <= 8'h0;
            bit_q  <= 3'h0;
            tx_q   <= 8'h0;
            rx_q   <= 8'h0;
            rxr_q  <= 8'h0;
            sck_q  <= 1'b0;
            mosi_q <= 1'b0;
            rst_q  <= 1'b0;
            wph_q  <= 1'b0;
            wa_q   <= 8'h0;
            rd_q   <= 32'h0;
            miso_q <= 1'b0;
            rdy_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            div_q  <= div_d;
            grd_q  <= grd_d;
            bit_q  <= bit_d;
            tx_q   <= tx_d;
            rx_q   <= rx_d;
            rxr_q  <= rxr_d;
            sck_q  <= sck_d;
            mosi_q <= mosi_d;
            rst_q  <= rst_d;
            wph_q  <= wph_d;
            wa_q   <= wa_d;
            rd_q   <= rd_d;
            miso_q <= miso_d;
            rdy_q  <= 1'b1;
        end
    end

    assign o_hrdata    = rd_q;
    assign o_hreadyout = rdy_q;
    assign o_hresp     = 1'b0;
    assign link.rst_pin = rst_q;
    assign link.sck     = sck_q;
    assign link.mosi    = mosi_q;
endmodule

/* File: pkg/isp_link_if.sv */
`timescale 1ns/100ps
interface isp_link_if;
    logic rst_pin;
    logic sck;
    logic mosi;
    logic miso;
    modport device (input rst_pin, input sck, input mosi, output miso);
    modport programmer (output rst_pin, output sck, output mosi,
                        input miso);
endinterface

/* File: pkg/isp_pkg.sv */
// What this block does
// - Enable is AC 53 xx xx; echo 69.
// - AC then 100xxxxx erases whole array.
// - Erase finishes within 500 ms.
// - Opcode 20 reads one byte, byte four.
// - Opcode 40 writes one byte, self-timed.
// - Byte write within 64 clocks plus 400 us.
// - AC then 111000xx writes lock bits.
// - Two select bits choose lock mode.
// - Programmer sets modes 2, 3 before 4.
// - Opcode 24 returns lock bits, set reads 1.
// - Page read 30, write 50, bytes 0-255.
// - After page address, all bytes are data.
// - After 256 page bytes, expect new command.
// - Clock low 64 clocks after reset high.
// - Serial clock at most 1/16 system clock.
// - Reset held high suffices, no pulse.
// - Instructions are four bytes, page excepted.
// - Enable must precede every other instruction.
// - Busy read of written byte inverts MSB.
// - Erase fills FF; reads during erase 00.
package isp_pkg;
    localparam int SYS_CLK_HZ    = 50_000_000;
    localparam int ERASE_TIME_MS = 500;
    localparam int WRITE_TIME_US = 400;
    localparam int WRITE_OSC_CYC = 64;
    localparam int ERASE_CYC     = (SYS_CLK_HZ / 1000) * ERASE_TIME_MS;
    localparam int WRITE_CYC     = WRITE_OSC_CYC
                                 + (SYS_CLK_HZ / 1_000_000) * WRITE_TIME_US;
    localparam int GUARD_CYC     = 64;
    localparam int SCK_MIN_DIV   = 16;
    localparam int SCK_HALF_CYC  = 16;
    localparam int PAGE_BYTES    = 256;
    localparam logic [7:0] OP_PREFIX   = 8'hac;
    localparam logic [7:0] OP_ENABLE2  = 8'h53;
    localparam logic [7:0] ENABLE_ECHO = 8'h69;
    localparam logic [2:0] ERASE_TAG   = 3'h4;
    localparam logic [5:0] LOCK_TAG    = 6'h38;
    localparam logic [7:0] OP_READ     = 8'h20;
    localparam logic [7:0] OP_WRITE    = 8'h40;
    localparam logic [7:0] OP_LOCK_RD  = 8'h24;
    localparam logic [7:0] OP_SIG      = 8'h28;
    localparam logic [7:0] OP_PAGE_RD  = 8'h30;
    localparam logic [7:0] OP_PAGE_WR  = 8'h50;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] ERASE_READ  = 8'h00;
    localparam int LOCK_RD_LSB   = 2;
    localparam int SEL_LOW_BIT   = 1;
    localparam int SEL_HIGH_BIT  = 0;
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_TXDATA = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_RXDATA = 8'h0c;
    localparam int CTRL_RST_BIT  = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_GRD_BIT  = 1;
endpackage

/* File: test/isp_link_checker.sv */
`timescale 1ns/100ps
module isp_link_checker
    import isp_pkg::*;
(
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Serial link.
    input wire logic rst_pin,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso
);
    logic [6:0]  guard_q, guard_d;
    logic [5:0]  bit_q, bit_d;
    logic [30:0] mo_q, mo_d;
    logic [6:0]  mi_q, mi_d;
    logic        sck_q;
    logic        last_bit;

    // Only the first frame of a session is decoded, so page data is never
    // mistaken for an instruction.
    always_comb begin
        guard_d = guard_q;
        bit_d   = bit_q;
        mo_d    = mo_q;
        mi_d    = mi_q;
        if (!rst_pin) begin
            guard_d = '0;
            bit_d   = '0;
        end else begin
            if (!guard_q[6]) begin
                guard_d = guard_q + 7'h01;
            end
            if (sck && !sck_q && bit_q != 6'h20) begin
                bit_d = bit_q + 6'h01;
                mo_d  = {mo_q[29:0], mosi};
                mi_d  = {mi_q[5:0], miso};
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            guard_q <= '0;
            bit_q   <= '0;
            mo_q    <= '0;
            mi_q    <= '0;
            sck_q   <= 1'b0;
        end else begin
            guard_q <= guard_d;
            bit_q   <= bit_d;
            mo_q    <= mo_d;
            mi_q    <= mi_d;
            sck_q   <= sck;
        end
    end

    assign last_bit = sck && !sck_q && bit_q == 6'h1f;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    guard_wait_a: assert property ($rose(sck) |-> guard_q[6])
        else $error("serial clock rose inside the guard time");
    sck_park_a: assert property (!rst_pin |-> !sck)
        else $error("serial clock high outside a session");
    sck_high_a: assert property ($rose(sck) |-> sck [*8])
        else $error("serial clock high phase too short");
    sck_low_a: assert property ($fell(sck) && rst_pin |-> !sck [*8])
        else $error("serial clock low phase too short");
    mosi_hold_a: assert property ($changed(mosi) |-> !sck)
        else $error("mosi changed while serial clock high");
    miso_hold_a: assert property
        ($rose(sck) |-> $stable(miso) [*8])
        else $error("miso changed while serial clock high");
    enable_echo_a: assert property
        (last_bit && mo_q[30:15] == {OP_PREFIX, OP_ENABLE2}
         |-> {mi_q, miso} == ENABLE_ECHO)
        else $error("enable echo byte wrong");
    locked_out_a: assert property
        (last_bit && mo_q[30:23] != OP_PREFIX |-> {mi_q, miso} == 8'h00)
        else $error("instruction answered before enable");

    cover property (last_bit && mo_q[30:15] == {OP_PREFIX, OP_ENABLE2});
    cover property (last_bit && mo_q[30:23] != OP_PREFIX);
    cover property ($fell(rst_pin));
endmodule

/* File: test/serial_isp_command_decoder_tb.sv */
`timescale 1ns/100ps
module serial_isp_command_decoder_tb
    import isp_pkg::*;
;
    localparam int ERASE_N = 3000;
    localparam int WRITE_N = 2000;
    localparam logic [7:0] SIG_N = 8'ha7;  // Arbitrary value.
    logic        i_sys_clk = 1'b0;
    logic        i_rstn    = 1'b0;
    logic        hsel      = 1'b0;
    logic [7:0]  haddr     = 8'h00;
    logic [1:0]  htrans    = 2'h0;
    logic        hwrite    = 1'b0;
    logic [31:0] hwdata    = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        prog_en;
    logic        busy;
    logic [2:0]  lock_bits;
    logic [31:0] rd;
    logic [7:0]  r4;
    int          mismatches  = 0;
    int          comparisons = 0;
    logic [11:0] at[4] = '{12'h123, 12'h000, 12'hfff, 12'h001};
    logic [7:0]  dt[4] = '{8'h5c, 8'h3a, 8'hc5, 8'hff};

    always #10 i_sys_clk = ~i_sys_clk;

    isp_link_if isp_link_if_i ();
    isp_device #(.ERASE_LEN(ERASE_N), .WRITE_LEN(WRITE_N),
                 .SIG_BASE(SIG_N)) isp_device_i (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .link(isp_link_if_i.device),
        .o_prog_enabled(prog_en), .o_busy(busy), .o_lock_bits(lock_bits));
    isp_programmer #(.HALF(8)) isp_programmer_i (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
        .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .link(isp_link_if_i.programmer));
    isp_link_checker isp_link_checker_i (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
        .rst_pin(isp_link_if_i.rst_pin), .sck(isp_link_if_i.sck),
        .mosi(isp_link_if_i.mosi), .miso(isp_link_if_i.miso));

    task finish_test;
        if (mismatches == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge i_sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge i_sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // The control read after the byte write gives the busy flag time to
    // rise before it is polled.
    task send(input logic [7:0] b);
        do ahb(1'b0, REG_STATUS, 32'h0); while (rd[1:0] !== 2'h0);
        ahb(1'b1, REG_TXDATA, {24'h0, b});
        ahb(1'b0, REG_CTRL, 32'h0);
        do ahb(1'b0, REG_STATUS, 32'h0); while (rd[STAT_BUSY_BIT] !== 1'b0);
        ahb(1'b0, REG_RXDATA, 32'h0);
        r4 = rd[7:0];
    endtask

    task frame(input logic [31:0] w);
        for (int i = 3; i >= 0; i--) send(w[8*i +: 8]);
    endtask

    task wait_idle(input int lim);
        for (int n = 0; n < lim && busy !== 1'b0; n++) @(posedge i_sys_clk);
    endtask

    initial begin
        repeat (150000) @(posedge i_sys_clk);
        mismatches++;
        finish_test;
    end

    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        @(posedge i_sys_clk);
        ahb(1'b0, REG_CTRL, 32'h0);
        check(rd, 32'h0);
        ahb(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0);
        check(32'(hresp), 32'h0);
        ahb(1'b1, REG_CTRL, 32'h1);
        ahb(1'b0, REG_CTRL, 32'h0);
        check(rd, 32'h1);
        frame({OP_PREFIX, OP_ENABLE2, 16'h0});
        check(32'(r4), 32'(ENABLE_ECHO));
        check(32'(prog_en), 32'h1);
        frame({OP_PREFIX, ERASE_TAG, 5'h1f, 16'h0});
        check(32'(busy), 32'h1);
        frame(32'h20012300);
        check(32'(r4), 32'(ERASE_READ));
        wait_idle(ERASE_N);
        check(32'(busy), 32'h0);
        frame(32'h20012300);
        check(32'(r4), 32'(ERASED_BYTE));
        frame({OP_WRITE, 4'h0, at[0], dt[0]});
        frame({OP_READ, 4'h0, at[0], 8'h00});
        check(32'(r4), {24'h0, ~dt[0][7], dt[0][6:0]});
        // Written while still busy, so the erased value must survive.
        frame({OP_WRITE, 4'h0, at[3], 8'h12});
        wait_idle(WRITE_N);
        check(32'(busy), 32'h0);
        for (int i = 1; i < 3; i++) begin
            frame({OP_WRITE, 4'h0, at[i], dt[i]});
            wait_idle(WRITE_N);
        end
        for (int i = 0; i < 4; i++) begin
            frame({OP_READ, 4'h0, at[i], 8'h00});
            check(32'(r4), 32'(dt[i]));
        end
        send(OP_PAGE_WR);
        send(8'h0e);
        for (int i = 0; i < PAGE_BYTES; i++) send(8'(i) ^ 8'h3c);
        wait_idle(WRITE_N);
        send(OP_PAGE_RD);
        send(8'h0e);
        for (int i = 0; i < PAGE_BYTES; i++) begin
            send(8'h00);
            check(32'(r4), 32'(8'(i) ^ 8'h3c));
        end
        frame(32'h200e0700);
        check(32'(r4), 32'h3b);
        frame({OP_SIG, 16'h0001, 8'h00});
        check(32'(r4), 32'(SIG_N ^ 8'h01));
        // Modes are requested in order, none first and the highest last.
        for (int i = 0; i < 4; i++) begin
            frame({OP_PREFIX, LOCK_TAG, 2'(i), 16'h0});
            wait_idle(WRITE_N);
            frame({OP_LOCK_RD, 24'h0});
            check(32'(r4[LOCK_RD_LSB +: 3]), 32'((1 << i) - 1));
            check(32'(lock_bits), 32'((1 << i) - 1));
        end
        ahb(1'b1, REG_CTRL, 32'h0);
        for (int n = 0; n < 50 && prog_en !== 1'b0; n++) @(posedge i_sys_clk);
        check(32'(prog_en), 32'h0);
        ahb(1'b1, REG_CTRL, 32'h1);
        frame({OP_READ, 4'h0, at[0], 8'h00});
        check(32'(r4), 32'h0);
        finish_test;
    end
endmodule
